// [include/cst_pkg.sv]
// shared constants and types for the transfer and skip timing unit
package cst_pkg;

  // machine-cycle divisors selected by processor_clock_control (core clocks per machine cycle)
  localparam logic [2:0] DIV_SEL0 = 3'h1;
  localparam logic [2:0] DIV_SEL1 = 3'h2;
  localparam logic [2:0] DIV_SEL2 = 3'h4;
  localparam logic [2:0] DIV_SEL3 = 3'h7;

  // machine-cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_TABLE = 2'h3;
  localparam logic [1:0] SKIP_SHORT = 2'h1;
  localparam logic [1:0] SKIP_LONG = 2'h2;

  // low pointer nibble wrap values that trigger a skip
  localparam logic [3:0] WRAP_INC = 4'h0;
  localparam logic [3:0] WRAP_DEC = 4'hf;

  // reset values
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [1:0] CNT_RST = 2'h0;
  localparam logic [2:0] DIV_RST = 3'h0;

  // address layout
  localparam int PC_W = 15;
  localparam int PC_HI_BIT = 14;
  localparam int B_VALID_W = 3;

  // instructions known to this unit; far-jump and vector ops only matter when skipped
  typedef enum logic [4:0] {
    OP_OTHER_ONE_BYTE,
    OP_OTHER_TWO_BYTE,
    OP_ABSOLUTE_BRANCH,
    OP_LONG_ABSOLUTE_BRANCH,
    OP_ABSOLUTE_CALL,
    OP_LONG_ABSOLUTE_SUBROUTINE_CALL,
    OP_TABLE_VECTOR_CALL,
    OP_LOAD_ACC_IMM,
    OP_LOAD_WIDE_ACC_IMM,
    OP_LOAD_POINTER_PAIR_IMM,
    OP_LOAD_LOW_INDEX_PAIR_IMM,
    OP_LOAD_BC_IMM,
    OP_LOAD_POST_INC,
    OP_LOAD_POST_DEC,
    OP_SWAP_OPERANDS_POST_INC,
    OP_SWAP_OPERANDS_POST_DEC,
    OP_ROM_TABLE_LOAD_PC_DE,
    OP_ROM_TABLE_LOAD_PC_XA,
    OP_ROM_TABLE_LOAD_ABS_DE,
    OP_ROM_TABLE_LOAD_ABS_ACC
  } cst_op_t;

  // string-effect groups
  typedef enum logic [1:0] {
    GRP_NONE,
    GRP_ACC,
    GRP_POINTER
  } cst_grp_t;

endpackage

// [hdl/cst_cycle_div.sv]
// machine-cycle tick generator from the processor clock control setting
`timescale 1ns/10ps
module cst_cycle_div (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // rate select
  input wire logic [1:0] processor_clock_control,
  // one-cycle pulse per machine cycle
  output logic machine_tick
);

  logic [2:0] div_cnt_r;
  logic [2:0] div_cnt_nxt;
  wire logic [2:0] div_last;

  // divisor lookup, one of four rates
  assign div_last = (processor_clock_control == 2'h0) ? cst_pkg::DIV_SEL0 - 3'h1 :
                    (processor_clock_control == 2'h1) ? cst_pkg::DIV_SEL1 - 3'h1 :
                    (processor_clock_control == 2'h2) ? cst_pkg::DIV_SEL2 - 3'h1 :
                                                        cst_pkg::DIV_SEL3 - 3'h1;
  assign machine_tick = (div_cnt_r >= div_last);
  assign div_cnt_nxt = machine_tick ? cst_pkg::DIV_RST : div_cnt_r + 3'h1;

  // divider counter
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_cnt_r <= cst_pkg::DIV_RST;
    end else begin
      div_cnt_r <= div_cnt_nxt;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // a rate change may cut the running machine cycle short once
  a_tick_rate_sel: assert property (machine_tick && $stable(processor_clock_control) |->
    div_cnt_r == div_last)
    else $error("machine tick not at selected divisor");
  a_tick_gap: assert property (machine_tick && div_last != 3'h0 |=>
    !machine_tick || $changed(processor_clock_control))
    else $error("machine ticks too close");

endmodule

// [hdl/cst_op_timing.sv]
// per-instruction cycle count, skip cost and string-effect group
`timescale 1ns/10ps
module cst_op_timing (
  // decoded instruction
  input wire cst_pkg::cst_op_t op,
  // timing results
  output logic [1:0] exec_cycles,
  output logic [1:0] skip_cycles,
  output cst_pkg::cst_grp_t group
);

  wire logic is_three_byte;
  wire logic is_table;
  wire logic is_step;
  wire logic is_two_byte;

  // only the four far jumps and calls count as three bytes; vector call does not
  assign is_three_byte = (op == cst_pkg::OP_ABSOLUTE_BRANCH) || (op == cst_pkg::OP_LONG_ABSOLUTE_BRANCH) ||
                         (op == cst_pkg::OP_ABSOLUTE_CALL) ||
                         (op == cst_pkg::OP_LONG_ABSOLUTE_SUBROUTINE_CALL);
  assign skip_cycles = is_three_byte ? cst_pkg::SKIP_LONG : cst_pkg::SKIP_SHORT;

  // execution cycle classes
  assign is_table = (op == cst_pkg::OP_ROM_TABLE_LOAD_PC_DE) || (op == cst_pkg::OP_ROM_TABLE_LOAD_PC_XA) ||
                    (op == cst_pkg::OP_ROM_TABLE_LOAD_ABS_DE) || (op == cst_pkg::OP_ROM_TABLE_LOAD_ABS_ACC);
  assign is_step = (op == cst_pkg::OP_LOAD_POST_INC) || (op == cst_pkg::OP_LOAD_POST_DEC) ||
                   (op == cst_pkg::OP_SWAP_OPERANDS_POST_INC) || (op == cst_pkg::OP_SWAP_OPERANDS_POST_DEC);
  assign is_two_byte = (op == cst_pkg::OP_LOAD_WIDE_ACC_IMM) || (op == cst_pkg::OP_LOAD_POINTER_PAIR_IMM) ||
                       (op == cst_pkg::OP_LOAD_LOW_INDEX_PAIR_IMM) || (op == cst_pkg::OP_LOAD_BC_IMM) ||
                       (op == cst_pkg::OP_OTHER_TWO_BYTE);
  assign exec_cycles = is_table ? cst_pkg::CYC_TABLE :
                       (is_step || is_two_byte) ? cst_pkg::CYC_TWO : cst_pkg::CYC_ONE;

  // string-effect grouping
  assign group = ((op == cst_pkg::OP_LOAD_ACC_IMM) || (op == cst_pkg::OP_LOAD_WIDE_ACC_IMM)) ? cst_pkg::GRP_ACC :
                 (op == cst_pkg::OP_LOAD_POINTER_PAIR_IMM) ? cst_pkg::GRP_POINTER :
                 cst_pkg::GRP_NONE;

endmodule

// [hdl/cst_transfer_unit.sv]
// transfer, table-load and skip timing unit of a 4-bit controller core
// Operation
// - a met skip condition costs extra machine cycles discarding the next instruction
// - skipping a one- or two-byte instruction costs one machine cycle
// - skipping a three-byte instruction costs two machine cycles
// - only the four far branches and calls count as three-byte instructions
// - skipping the table vector call always costs one machine cycle
// - one machine cycle is one cpu clock period; counts use these periods
// - cpu clock period is chosen among four rates by clock control
// - post-increment load: A gets nibble, L increments, 2+S cycles, skip on L=0
// - post-decrement load: A gets nibble, L decrements, 2+S cycles, skip on L=F
// - swap with post step: exchange A and nibble, step L, skip on wrap
// - pc-relative table loads take 3 cycles; high part from PC13-8 or PC14-8
// - absolute table loads use only the low three bits of B
// - absolute table addresses reach 3fff in legacy mode, 7fff in extended mode
// - in legacy mode program counter bit 14 is held at zero
`timescale 1ns/10ps
module cst_transfer_unit (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // mode and rate
  input wire logic [1:0] processor_clock_control,
  input wire logic extended_compat_mode,
  input wire logic [14:0] pc_value,
  // instruction issue
  input wire logic instr_valid,
  input wire cst_pkg::cst_op_t instr_op,
  input wire logic [7:0] instr_imm,
  output logic instr_ready,
  output logic skip_pending,
  output logic skip_busy,
  output logic machine_tick,
  // data memory
  output logic [7:0] ram_addr,
  input wire logic [3:0] ram_rdata,
  output logic [3:0] ram_wdata,
  output logic ram_we,
  // program memory
  output logic [14:0] rom_addr,
  input wire logic [7:0] rom_rdata,
  // register state
  output logic [3:0] acc_a,
  output logic [3:0] acc_x,
  output logic [3:0] ptr_h,
  output logic [3:0] ptr_l,
  output logic [3:0] idx_d,
  output logic [3:0] idx_e,
  output logic [3:0] reg_b,
  output logic [3:0] reg_c
);

  logic [3:0] acc_a_r, acc_x_r, ptr_h_r, ptr_l_r, idx_d_r, idx_e_r, reg_b_r, reg_c_r;
  logic [3:0] acc_a_nxt, acc_x_nxt, ptr_h_nxt, ptr_l_nxt, idx_d_nxt, idx_e_nxt, reg_b_nxt, reg_c_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic skip_pending_r;
  logic skip_pending_nxt;
  logic skip_busy_r;
  logic skip_busy_nxt;
  cst_pkg::cst_grp_t last_grp_r;
  cst_pkg::cst_grp_t last_grp_nxt;

  wire logic [1:0] exec_cycles;
  wire logic [1:0] skip_cycles;
  wire cst_pkg::cst_grp_t op_grp;

  // machine-cycle tick
  cst_cycle_div u_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .processor_clock_control(processor_clock_control),
    .machine_tick(machine_tick)
  );

  // per-op timing decode
  cst_op_timing u_timing (
    .op(instr_op),
    .exec_cycles(exec_cycles),
    .skip_cycles(skip_cycles),
    .group(op_grp)
  );

  // issue handshake: a new op starts only on a machine-cycle boundary
  wire logic accept;
  wire logic string_hit;
  wire logic discard;
  wire logic exec_do;
  assign instr_ready = machine_tick && (cnt_r <= 2'h1);
  assign accept = instr_ready && instr_valid;
  assign string_hit = (op_grp != cst_pkg::GRP_NONE) && (op_grp == last_grp_r);
  assign discard = skip_pending_r || string_hit;
  assign exec_do = accept && !discard;

  // op class decode
  wire logic op_step_inc;
  wire logic op_step_dec;
  wire logic op_swap;
  wire logic op_load_mem;
  wire logic op_tbl_pc;
  wire logic op_tbl_abs;
  wire logic op_tbl_xa;
  assign op_step_inc = (instr_op == cst_pkg::OP_LOAD_POST_INC) || (instr_op == cst_pkg::OP_SWAP_OPERANDS_POST_INC);
  assign op_step_dec = (instr_op == cst_pkg::OP_LOAD_POST_DEC) || (instr_op == cst_pkg::OP_SWAP_OPERANDS_POST_DEC);
  assign op_swap = (instr_op == cst_pkg::OP_SWAP_OPERANDS_POST_INC) ||
                   (instr_op == cst_pkg::OP_SWAP_OPERANDS_POST_DEC);
  assign op_load_mem = op_step_inc || op_step_dec;
  assign op_tbl_pc = (instr_op == cst_pkg::OP_ROM_TABLE_LOAD_PC_DE) || (instr_op == cst_pkg::OP_ROM_TABLE_LOAD_PC_XA);
  assign op_tbl_abs = (instr_op == cst_pkg::OP_ROM_TABLE_LOAD_ABS_DE) ||
                      (instr_op == cst_pkg::OP_ROM_TABLE_LOAD_ABS_ACC);
  assign op_tbl_xa = (instr_op == cst_pkg::OP_ROM_TABLE_LOAD_PC_XA) ||
                     (instr_op == cst_pkg::OP_ROM_TABLE_LOAD_ABS_ACC);

  // low pointer step and wrap detection
  wire logic [3:0] l_step;
  wire logic step_wrap;
  assign l_step = op_step_inc ? ptr_l_r + 4'h1 : ptr_l_r - 4'h1;
  assign step_wrap = op_step_inc ? (l_step == cst_pkg::WRAP_INC) : (l_step == cst_pkg::WRAP_DEC);

  // table address forming
  wire logic [14:0] pc_eff;
  wire logic [7:0] tbl_lo;
  wire logic [14:0] abs_addr;
  assign pc_eff = {pc_value[cst_pkg::PC_HI_BIT] & extended_compat_mode,
                   pc_value[cst_pkg::PC_HI_BIT-1:0]};
  assign tbl_lo = op_tbl_xa ? {acc_x_r, acc_a_r} : {idx_d_r, idx_e_r};
  assign abs_addr = {reg_b_r[cst_pkg::B_VALID_W-1] & extended_compat_mode,
                     reg_b_r[cst_pkg::B_VALID_W-2:0], reg_c_r, tbl_lo};
  assign rom_addr = op_tbl_pc ? {pc_eff[cst_pkg::PC_HI_BIT:8], tbl_lo} : abs_addr;

  // data memory port
  assign ram_addr = {ptr_h_r, ptr_l_r};
  assign ram_wdata = acc_a_r;
  assign ram_we = exec_do && op_swap;

  // accumulator next values
  wire logic wr_acc_imm;
  wire logic wr_wide_imm;
  wire logic wr_tbl;
  assign wr_acc_imm = exec_do && (instr_op == cst_pkg::OP_LOAD_ACC_IMM);
  assign wr_wide_imm = exec_do && (instr_op == cst_pkg::OP_LOAD_WIDE_ACC_IMM);
  assign wr_tbl = exec_do && (op_tbl_pc || op_tbl_abs);
  assign acc_a_nxt = (wr_acc_imm || wr_wide_imm) ? instr_imm[3:0] :
                     wr_tbl ? rom_rdata[3:0] :
                     (exec_do && op_load_mem) ? ram_rdata : acc_a_r;
  assign acc_x_nxt = wr_wide_imm ? instr_imm[7:4] : wr_tbl ? rom_rdata[7:4] : acc_x_r;

  // pointer and index pair next values
  wire logic wr_hl;
  wire logic wr_de;
  wire logic wr_bc;
  assign wr_hl = exec_do && (instr_op == cst_pkg::OP_LOAD_POINTER_PAIR_IMM);
  assign wr_de = exec_do && (instr_op == cst_pkg::OP_LOAD_LOW_INDEX_PAIR_IMM);
  assign wr_bc = exec_do && (instr_op == cst_pkg::OP_LOAD_BC_IMM);
  assign ptr_h_nxt = wr_hl ? instr_imm[7:4] : ptr_h_r;
  assign ptr_l_nxt = wr_hl ? instr_imm[3:0] : (exec_do && op_load_mem) ? l_step : ptr_l_r;
  assign idx_d_nxt = wr_de ? instr_imm[7:4] : idx_d_r;
  assign idx_e_nxt = wr_de ? instr_imm[3:0] : idx_e_r;
  assign reg_b_nxt = wr_bc ? instr_imm[7:4] : reg_b_r;
  assign reg_c_nxt = wr_bc ? instr_imm[3:0] : reg_c_r;

  // cycle budget, skip request and string-effect history
  assign cnt_nxt = accept ? (discard ? skip_cycles : exec_cycles) :
                   (machine_tick && cnt_r != cst_pkg::CNT_RST) ? cnt_r - 2'h1 : cnt_r;
  assign skip_pending_nxt = accept ? (exec_do && op_load_mem && step_wrap) : skip_pending_r;
  assign skip_busy_nxt = accept ? discard : skip_busy_r;
  assign last_grp_nxt = accept ? op_grp : last_grp_r;

  // status outputs
  assign skip_pending = skip_pending_r;
  assign skip_busy = skip_busy_r && (cnt_r != cst_pkg::CNT_RST);
  assign acc_a = acc_a_r;
  assign acc_x = acc_x_r;
  assign ptr_h = ptr_h_r;
  assign ptr_l = ptr_l_r;
  assign idx_d = idx_d_r;
  assign idx_e = idx_e_r;
  assign reg_b = reg_b_r;
  assign reg_c = reg_c_r;

  // register file
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      acc_a_r <= cst_pkg::NIB_RST;
      acc_x_r <= cst_pkg::NIB_RST;
      ptr_h_r <= cst_pkg::NIB_RST;
      ptr_l_r <= cst_pkg::NIB_RST;
      idx_d_r <= cst_pkg::NIB_RST;
      idx_e_r <= cst_pkg::NIB_RST;
      reg_b_r <= cst_pkg::NIB_RST;
      reg_c_r <= cst_pkg::NIB_RST;
    end else begin
      acc_a_r <= acc_a_nxt;
      acc_x_r <= acc_x_nxt;
      ptr_h_r <= ptr_h_nxt;
      ptr_l_r <= ptr_l_nxt;
      idx_d_r <= idx_d_nxt;
      idx_e_r <= idx_e_nxt;
      reg_b_r <= reg_b_nxt;
      reg_c_r <= reg_c_nxt;
    end
  end

  // sequencing state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_r <= cst_pkg::CNT_RST;
      skip_pending_r <= 1'b0;
      skip_busy_r <= 1'b0;
      last_grp_r <= cst_pkg::GRP_NONE;
    end else begin
      cnt_r <= cnt_nxt;
      skip_pending_r <= skip_pending_nxt;
      skip_busy_r <= skip_busy_nxt;
      last_grp_r <= last_grp_nxt;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // discarding accept of a short or long instruction
  sequence s_discard_short;
    accept && discard && (skip_cycles == cst_pkg::SKIP_SHORT);
  endsequence
  sequence s_discard_long;
    accept && skip_pending_r && (skip_cycles == cst_pkg::SKIP_LONG);
  endsequence
  sequence s_step_exec;
    exec_do && op_load_mem;
  endsequence

  a_skip_short_cost: assert property (s_discard_short |=> cnt_r == 2'h1)
    else $error("short skip not one machine cycle");
  a_skip_long_cost: assert property (s_discard_long |=> cnt_r == 2'h2)
    else $error("long skip not two machine cycles");
  a_far_ops_long: assert property (accept && (instr_op == cst_pkg::OP_ABSOLUTE_CALL) |->
    skip_cycles == 2'h2)
    else $error("absolute call not treated as three bytes");
  a_vector_skip_one: assert property (accept && skip_pending_r && (instr_op == cst_pkg::OP_TABLE_VECTOR_CALL)
    |=> cnt_r == 2'h1)
    else $error("vector call skip not one cycle");
  a_inc_load_skip: assert property (s_step_exec and op_step_inc |=>
    (acc_a_r == $past(ram_rdata)) && (ptr_l_r == $past(ptr_l_r) + 4'h1) &&
    (skip_pending_r == (ptr_l_r == 4'h0)) && (cnt_r == 2'h2))
    else $error("post-increment load wrong");
  a_dec_load_skip: assert property (s_step_exec and op_step_dec |=>
    (ptr_l_r == $past(ptr_l_r) - 4'h1) && (skip_pending_r == (ptr_l_r == 4'hf)))
    else $error("post-decrement load wrong");
  a_swap_write_back: assert property (exec_do && op_swap |-> ram_we && (ram_wdata == acc_a_r)
    ##1 (acc_a_r == $past(ram_rdata)) && !ram_we)
    else $error("swap did not exchange");
  a_table_three_cyc: assert property (exec_do && (op_tbl_pc || op_tbl_abs) |=> (cnt_r == 2'h3)
    && ({acc_x_r, acc_a_r} == $past(rom_rdata)))
    else $error("table load wrong");
  a_abs_b_bits: assert property (op_tbl_abs |-> rom_addr[13:12] == reg_b_r[1:0])
    else $error("absolute table uses wrong b bits");
  a_legacy_range: assert property (!extended_compat_mode |-> !rom_addr[14])
    else $error("legacy mode address above 3fff");
  a_string_skip_grp: assert property (accept && string_hit |=> $stable(acc_a_r) && $stable(ptr_l_r)
    && skip_busy)
    else $error("string-effect op not skipped");
  a_skip_no_effect: assert property (accept && discard |-> !ram_we ##1 $stable(acc_x_r) &&
    $stable(ptr_h_r) && $stable(reg_c_r) && !skip_pending_r)
    else $error("skipped op had an effect");
  a_cycle_hold: assert property (!machine_tick && !accept |=> $stable(cnt_r))
    else $error("cycle count moved between machine cycles");

endmodule

// [dv/cst_mem_model.sv]
// behavioural program rom and data ram facing the transfer unit
`timescale 1ns/10ps
module cst_mem_model (
  // clock
  input wire logic core_clk,
  // data memory
  input wire logic [7:0] ram_addr,
  output logic [3:0] ram_rdata,
  input wire logic [3:0] ram_wdata,
  input wire logic ram_we,
  // program memory
  input wire logic [14:0] rom_addr,
  output logic [7:0] rom_rdata
);
  logic [3:0] mem [256];
  // fixed start pattern, mirrored by the bench
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 4'(i ^ (i >> 4));
    end
  end
  // write on the take clock of a swap
  always @(posedge core_clk) begin
    if (ram_we) begin
      mem[ram_addr] <= ram_wdata;
    end
  end
  // combinational reads, rom data depends on every address bit
  assign ram_rdata = mem[ram_addr];
  assign rom_rdata = rom_addr[7:0] ^ {1'b0, rom_addr[14:8]} ^ 8'h5a;
endmodule

// [dv/cpu_transfer_skip_timing_tb.sv]
// self-checking bench for the transfer and skip timing unit
`timescale 1ns/10ps
module cpu_transfer_skip_timing_tb;
  typedef struct {int gap; logic [31:0] regs; logic pend; logic busy; logic [4:0] wr;} cst_note_t;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] processor_clock_control = 2'h0;
  logic extended_compat_mode = 1'b0;
  logic [14:0] pc_value = 15'h0;
  logic instr_valid = 1'b0;
  cst_pkg::cst_op_t instr_op = cst_pkg::OP_OTHER_ONE_BYTE;
  logic [7:0] instr_imm = 8'h00;
  logic instr_ready, skip_pending, skip_busy, machine_tick, ram_we;
  logic [7:0] ram_addr, rom_rdata;
  logic [3:0] ram_rdata, ram_wdata, acc_a, acc_x, ptr_h, ptr_l, idx_d, idx_e, reg_b, reg_c;
  logic [14:0] rom_addr;
  logic [3:0] sh [8];
  logic [3:0] smem [256];
  logic sh_skip = 1'b0;
  cst_pkg::cst_grp_t sh_grp = cst_pkg::GRP_NONE;
  int sh_cost = 0;
  cst_note_t q [$];
  cst_note_t n;
  logic take_d = 1'b0;
  logic [4:0] wr_d = 5'h0;
  int ticks = 0;
  int gap_seen = 0;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  cst_pkg::cst_op_t victims [9] = '{cst_pkg::OP_OTHER_ONE_BYTE, cst_pkg::OP_OTHER_TWO_BYTE,
    cst_pkg::OP_ABSOLUTE_BRANCH, cst_pkg::OP_LONG_ABSOLUTE_BRANCH, cst_pkg::OP_ABSOLUTE_CALL,
    cst_pkg::OP_LONG_ABSOLUTE_SUBROUTINE_CALL, cst_pkg::OP_TABLE_VECTOR_CALL,
    cst_pkg::OP_LOAD_ACC_IMM, cst_pkg::OP_LOAD_WIDE_ACC_IMM};
  cst_pkg::cst_op_t steps [4] = '{cst_pkg::OP_LOAD_POST_INC, cst_pkg::OP_LOAD_POST_DEC,
    cst_pkg::OP_SWAP_OPERANDS_POST_INC, cst_pkg::OP_SWAP_OPERANDS_POST_DEC};
  cst_pkg::cst_op_t tables [4] = '{cst_pkg::OP_ROM_TABLE_LOAD_PC_DE, cst_pkg::OP_ROM_TABLE_LOAD_PC_XA,
    cst_pkg::OP_ROM_TABLE_LOAD_ABS_DE, cst_pkg::OP_ROM_TABLE_LOAD_ABS_ACC};

  cst_transfer_unit cst_transfer_unit_inst (.core_clk(core_clk), .rst_n(rst_n),
    .processor_clock_control(processor_clock_control), .extended_compat_mode(extended_compat_mode),
    .pc_value(pc_value), .instr_valid(instr_valid), .instr_op(instr_op), .instr_imm(instr_imm),
    .instr_ready(instr_ready), .skip_pending(skip_pending), .skip_busy(skip_busy),
    .machine_tick(machine_tick), .ram_addr(ram_addr), .ram_rdata(ram_rdata), .ram_wdata(ram_wdata),
    .ram_we(ram_we), .rom_addr(rom_addr), .rom_rdata(rom_rdata), .acc_a(acc_a), .acc_x(acc_x),
    .ptr_h(ptr_h), .ptr_l(ptr_l), .idx_d(idx_d), .idx_e(idx_e), .reg_b(reg_b), .reg_c(reg_c));
  cst_mem_model cst_mem_model_inst (.core_clk(core_clk), .ram_addr(ram_addr), .ram_rdata(ram_rdata),
    .ram_wdata(ram_wdata), .ram_we(ram_we), .rom_addr(rom_addr), .rom_rdata(rom_rdata));

  // 25 mhz core clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // predict the op's effect, note it, then offer it until taken
  task automatic issue(input cst_pkg::cst_op_t op, input logic [7:0] imm, input logic [14:0] pc);
    cst_pkg::cst_grp_t g;
    cst_note_t e;
    logic inc, swp;
    logic [3:0] t;
    logic [6:0] hi;
    logic [14:0] ra;
    int cnt;
    e.gap = sh_cost;
    e.busy = 1'b0;
    e.wr = 5'h0;
    g = (op inside {cst_pkg::OP_LOAD_ACC_IMM, cst_pkg::OP_LOAD_WIDE_ACC_IMM}) ? cst_pkg::GRP_ACC :
        (op == cst_pkg::OP_LOAD_POINTER_PAIR_IMM) ? cst_pkg::GRP_POINTER : cst_pkg::GRP_NONE;
    inc = op inside {cst_pkg::OP_LOAD_POST_INC, cst_pkg::OP_SWAP_OPERANDS_POST_INC};
    swp = op inside {cst_pkg::OP_SWAP_OPERANDS_POST_INC, cst_pkg::OP_SWAP_OPERANDS_POST_DEC};
    hi = {pc[14] & extended_compat_mode, pc[13:8]};
    if (sh_skip || (g != cst_pkg::GRP_NONE && g == sh_grp)) begin
      // discarded: state untouched, costs one or two cycles
      sh_cost = (op inside {cst_pkg::OP_ABSOLUTE_BRANCH, cst_pkg::OP_LONG_ABSOLUTE_BRANCH, cst_pkg::OP_ABSOLUTE_CALL,
        cst_pkg::OP_LONG_ABSOLUTE_SUBROUTINE_CALL}) ? 2 : 1;
      sh_skip = 1'b0;
      e.busy = 1'b1;
    end else begin
      sh_cost = (op inside {cst_pkg::OP_LOAD_ACC_IMM, cst_pkg::OP_OTHER_ONE_BYTE}) ? 1 : 2;
      case (op)
        cst_pkg::OP_LOAD_ACC_IMM: sh[0] = imm[3:0];
        cst_pkg::OP_LOAD_WIDE_ACC_IMM: {sh[1], sh[0]} = imm;
        cst_pkg::OP_LOAD_POINTER_PAIR_IMM: {sh[2], sh[3]} = imm;
        cst_pkg::OP_LOAD_LOW_INDEX_PAIR_IMM: {sh[4], sh[5]} = imm;
        cst_pkg::OP_LOAD_BC_IMM: {sh[6], sh[7]} = imm;
        cst_pkg::OP_OTHER_ONE_BYTE, cst_pkg::OP_OTHER_TWO_BYTE: t = 4'h0;
        default: begin
          if (op inside {steps}) begin
            t = smem[{sh[2], sh[3]}];
            if (swp) begin
              e.wr = {1'b1, sh[0]};
              smem[{sh[2], sh[3]}] = sh[0];
            end
            sh[0] = t;
            sh[3] = inc ? sh[3] + 4'h1 : sh[3] - 4'h1;
            sh_skip = (sh[3] == (inc ? 4'h0 : 4'hf));
          end else if (op inside {tables}) begin
            sh_cost = 3;
            ra = (op == cst_pkg::OP_ROM_TABLE_LOAD_PC_DE) ? {hi, sh[4], sh[5]} :
                 (op == cst_pkg::OP_ROM_TABLE_LOAD_PC_XA) ? {hi, sh[1], sh[0]} :
                 {sh[6][2] & extended_compat_mode, sh[6][1:0], sh[7],
                  (op == cst_pkg::OP_ROM_TABLE_LOAD_ABS_DE) ? {sh[4], sh[5]} : {sh[1], sh[0]}};
            {sh[1], sh[0]} = ra[7:0] ^ {1'b0, ra[14:8]} ^ 8'h5a;
          end else begin
            sh_cost = 0;
          end
        end
      endcase
    end
    sh_grp = g;
    e.regs = {sh[0], sh[1], sh[2], sh[3], sh[4], sh[5], sh[6], sh[7]};
    e.pend = sh_skip;
    q.push_back(e);
    instr_op <= op;
    instr_imm <= imm;
    pc_value <= pc;
    instr_valid <= 1'b1;
    cnt = 0;
    while (instr_ready !== 1'b1 && cnt < 200) begin
      @(negedge core_clk);
      cnt++;
    end
    check(32'(cnt < 200), 32'h1);
    @(negedge core_clk);
  endtask

  task automatic finish_test(input string name);
    instr_valid <= 1'b0;
    repeat (4) @(negedge core_clk);
    sh_cost = 0;
    $display("test %s done", name);
  endtask

  // step op that wraps, then the discarded victim, then a timed follower
  task automatic skip_case(input cst_pkg::cst_op_t victim, input int k);
    issue(cst_pkg::OP_LOAD_POINTER_PAIR_IMM, {4'($urandom()), (k % 2 == 0) ? 4'hf : 4'h0}, 15'h0);
    issue(steps[k % 4], 8'h00, 15'h0);
    issue(victim, 8'($urandom()), 15'h0);
    issue(cst_pkg::OP_OTHER_ONE_BYTE, 8'h00, 15'h0);
  endtask

  task automatic rate_check(input logic [1:0] r, input logic [2:0] per);
    int c;
    processor_clock_control <= r;
    repeat (16) @(negedge core_clk);
    c = 0;
    while (machine_tick !== 1'b1 && c < 20) begin
      @(negedge core_clk);
      c++;
    end
    c = 0;
    do begin
      @(negedge core_clk);
      c++;
    end while (machine_tick !== 1'b1 && c < 20);
    check(32'(c), 32'(per));
  endtask

  // sample each take and count machine ticks between takes
  always @(posedge core_clk) begin
    take_d <= (instr_valid === 1'b1) && (instr_ready === 1'b1);
    wr_d <= (ram_we === 1'b1) ? {1'b1, ram_wdata} : 5'h0;
    if (!rst_n) begin
      ticks <= 0;
    end else if (instr_valid === 1'b1 && instr_ready === 1'b1) begin
      gap_seen <= ticks + 1;
      ticks <= 0;
    end else if (machine_tick === 1'b1) begin
      ticks <= ticks + 1;
    end
  end

  // compare the oldest note once a take has landed
  always @(negedge core_clk) begin
    if (take_d && q.size() > 0) begin
      n = q.pop_front();
      check({acc_a, acc_x, ptr_h, ptr_l, idx_d, idx_e, reg_b, reg_c}, n.regs);
      check(32'(skip_pending), 32'(n.pend));
      check(32'(skip_busy), 32'(n.busy));
      check(32'(wr_d), 32'(n.wr));
      if (n.gap != 0) begin
        check(32'(gap_seen), 32'(n.gap));
      end
    end
  end

  // watchdog
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      summarize();
    end
  end

  // main sequence
  initial begin
    void'($urandom(32'h874ae9e8));
    for (int i = 0; i < 256; i++) begin
      smem[i] = 4'(i ^ (i >> 4));
    end
    for (int i = 0; i < 8; i++) begin
      sh[i] = 4'h0;
    end
    repeat (4) @(negedge core_clk);
    check({acc_a, acc_x, ptr_h, ptr_l, idx_d, idx_e, reg_b, reg_c}, 32'h0);
    check({30'h0, skip_pending, ram_we}, 32'h0);
    rst_n <= 1'b1;
    @(negedge core_clk);
    finish_test("reset");
    issue(cst_pkg::OP_LOAD_LOW_INDEX_PAIR_IMM, 8'($urandom()), 15'h0);
    issue(cst_pkg::OP_LOAD_BC_IMM, 8'($urandom()), 15'h0);
    issue(cst_pkg::OP_LOAD_POINTER_PAIR_IMM, 8'($urandom()), 15'h0);
    issue(cst_pkg::OP_LOAD_POINTER_PAIR_IMM, 8'($urandom()), 15'h0);
    issue(cst_pkg::OP_LOAD_ACC_IMM, 8'($urandom()), 15'h0);
    issue(cst_pkg::OP_LOAD_WIDE_ACC_IMM, 8'($urandom()), 15'h0);
    issue(cst_pkg::OP_LOAD_ACC_IMM, 8'($urandom()), 15'h0);
    issue(cst_pkg::OP_OTHER_TWO_BYTE, 8'h00, 15'h0);
    issue(cst_pkg::OP_LOAD_ACC_IMM, 8'($urandom()), 15'h0);
    finish_test("string effect");
    for (int k = 0; k < 9; k++) begin
      skip_case(victims[k], k);
    end
    finish_test("skip cost");
    for (int m = 0; m < 2; m++) begin
      extended_compat_mode <= m[0];
      @(negedge core_clk);
      issue(cst_pkg::OP_LOAD_BC_IMM, 8'($urandom()) | 8'h40, 15'h0);
      issue(cst_pkg::OP_LOAD_LOW_INDEX_PAIR_IMM, 8'($urandom()), 15'h0);
      issue(cst_pkg::OP_LOAD_WIDE_ACC_IMM, 8'($urandom()), 15'h0);
      for (int j = 0; j < 4; j++) begin
        issue(tables[j], 8'h00, 15'($urandom()) | 15'h4000);
      end
      issue(cst_pkg::OP_OTHER_ONE_BYTE, 8'h00, 15'h0);
      finish_test("table load");
    end
    processor_clock_control <= 2'h3;
    repeat (16) @(negedge core_clk);
    skip_case(cst_pkg::OP_LONG_ABSOLUTE_SUBROUTINE_CALL, 3);
    skip_case(cst_pkg::OP_TABLE_VECTOR_CALL, 0);
    finish_test("slow rate");
    rate_check(2'h0, cst_pkg::DIV_SEL0);
    rate_check(2'h1, cst_pkg::DIV_SEL1);
    rate_check(2'h2, cst_pkg::DIV_SEL2);
    rate_check(2'h3, cst_pkg::DIV_SEL3);
    finish_test("clock rates");
    summarize();
  end
endmodule
